// file: logic/dpf_consts.svh
// Purpose: constants of the dual partition flash map
// Assumes: 24-bit program space, AHB-Lite register window
// Notes: included by the map module only
`ifndef DPF_CONSTS_SVH
`define DPF_CONSTS_SVH
`define DPF_USER_TOP 24'h7FFFFF
`define DPF_INACT_BASE 24'h400000
`define DPF_RST_END 24'h000004
`define DPF_PRIM_VEC_END 24'h000100
`define DPF_VEC_END 24'h000200
`define DPF_PAGE_SHIFT 11
`define DPF_OTP_LO 24'h801700
`define DPF_OTP_HI 24'h8017FF
`define DPF_CFG_LO 24'h801800
`define DPF_CFG_HI 24'h801FFF
`define DPF_FBOOT_ADDR 24'h801800
`define DPF_SEQ1_ADDR 24'h055FFC
`define DPF_SEQ2_ADDR 24'h455FFC
`define DPF_LIM_DUAL 24'h055F10
`define DPF_LIM_SINGLE 24'h0ABF10
`define DPF_SEC_DUAL 24'h055F00
`define DPF_SEQ_MAX 12'hFFF
`define DPF_ROW_MASK 24'hFFFF00
`define DPF_PAGE_MASK 24'hFFF800
`define DPF_OFS_CTRL 5'h00
`define DPF_OFS_STATUS 5'h04
`define DPF_OFS_PADDR 5'h08
`define DPF_OFS_PCMD 5'h0C
`define DPF_OFS_SEQ1 5'h10
`define DPF_OFS_SEQ2 5'h14
`define DPF_OFS_LIM 5'h18
`endif

// file: logic/dpf_pkg.sv
// Purpose: types of the dual partition flash map
// Assumes: nothing beyond the consts header
// Notes: encodings are fixed, the bench may decode them
package dpf_pkg;
	typedef enum logic [2:0] {
		LD_START = 3'b000,
		LD_FBOOT = 3'b001,
		LD_SEQ1 = 3'b010,
		LD_SEQ2 = 3'b011,
		LD_LIM = 3'b100,
		LD_SEC = 3'b101,
		LD_RUN = 3'b110
	} dpf_load_t;
	typedef enum logic [1:0] {
		ACC_FETCH = 2'b00,
		ACC_TBL_RD = 2'b01,
		ACC_TBL_WR = 2'b10,
		ACC_REMAP = 2'b11
	} dpf_kind_t;
	typedef enum logic [3:0] {
		RG_RESET = 4'h0,
		RG_PRIM_VEC = 4'h1,
		RG_VEC_RSVD = 4'h2,
		RG_ALT_VEC = 4'h3,
		RG_BOOT = 4'h4,
		RG_GEN = 4'h5,
		RG_INACT = 4'h6,
		RG_CFG = 4'h7,
		RG_OTP = 4'h8,
		RG_NONE = 4'hF
	} dpf_region_t;
	typedef struct packed {
		logic valid;
		dpf_kind_t kind;
		logic [22:0] pc;
		logic [7:0] table_page_reg;
		logic [15:0] offset;
	} dpf_acc_t;
	typedef struct packed {
		logic valid;
		logic err;
		logic upper_word;
		logic phys_part;
		dpf_region_t region;
		logic [23:0] laddr;
		logic [23:0] paddr;
	} dpf_map_t;
endpackage

// file: logic/dpf_flash_map.sv
// Purpose: program space map and active partition selection
// Assumes: core access port on hclk, flash config read one cycle after address
// Notes: single clock domain; every flop holds while ce is low
`timescale 1ns/10ps
`include "dpf_consts.svh"
module dpf_flash_map (
	input wire logic hclk, // 10 MHz system clock
	input wire logic hresetn, // Async reset, active low
	input wire logic ce, // Clock enable, freezes state when low
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic hreadyout, // AHB ready out
	output logic hresp, // AHB response
	output logic [31:0] hrdata, // AHB read data
	output logic [23:0] cfg_addr, // Config word read address
	input wire logic [23:0] cfg_rdata, // Config word read data
	input wire dpf_pkg::dpf_acc_t acc, // Core access request
	output dpf_pkg::dpf_map_t map, // Mapped access
	output logic cfg_done, // Configuration loaded
	output logic second_partition_active_flag, // Partition 2 active
	output logic prog_go, // Program/erase pulse
	output logic [1:0] prog_kind, // 1 row write, 2 page erase, 3 chip erase
	output logic [23:0] prog_addr // Block-aligned target
);
	// ==========================================================
	// Functions
	function automatic logic seq_ok(input logic [23:0] w);
		seq_ok = (w[23:12] == ~w[11:0]);
	endfunction
	function automatic logic [11:0] seq_val(input logic [23:0] w);
		seq_val = seq_ok(w) ? w[11:0] : `DPF_SEQ_MAX;
	endfunction
	function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	// ==========================================================
	// Configuration load
	dpf_pkg::dpf_load_t ld_q;
	logic dual_q;
	logic [23:0] seq1_q;
	logic [23:0] seq2_q;
	logic [12:0] lim_q;
	logic alt_vec_dis_q;
	logic inact_wp_q;
	logic reset_sel_q;
	logic active_q;
	logic sel_d;
	always_comb begin
		if (!seq_ok(seq1_q) && !seq_ok(cfg_rdata)) begin
			sel_d = 1'b0;
		end else if (seq_ok(seq1_q) != seq_ok(cfg_rdata)) begin
			sel_d = !seq_ok(seq1_q);
		end else begin
			sel_d = seq_val(cfg_rdata) < seq_val(seq1_q);
		end
	end
	// Selection only moves in the reset-time load, later reprogramming waits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ld_q <= dpf_pkg::LD_START;
			cfg_addr <= 24'h000000;
			dual_q <= 1'b0;
			seq1_q <= 24'h000000;
			seq2_q <= 24'h000000;
			lim_q <= 13'h0000;
			alt_vec_dis_q <= 1'b1;
			inact_wp_q <= 1'b0;
			reset_sel_q <= 1'b0;
			cfg_done <= 1'b0;
		end else if (ce) begin
			unique case (ld_q)
				dpf_pkg::LD_START: begin
					cfg_addr <= `DPF_FBOOT_ADDR;
					ld_q <= dpf_pkg::LD_FBOOT;
				end
				dpf_pkg::LD_FBOOT: begin
					dual_q <= (cfg_rdata[1:0] != 2'b11);
					cfg_addr <= `DPF_SEQ1_ADDR;
					ld_q <= dpf_pkg::LD_SEQ1;
				end
				dpf_pkg::LD_SEQ1: begin
					seq1_q <= cfg_rdata;
					cfg_addr <= `DPF_SEQ2_ADDR;
					ld_q <= dpf_pkg::LD_SEQ2;
				end
				dpf_pkg::LD_SEQ2: begin
					seq2_q <= cfg_rdata;
					reset_sel_q <= dual_q & sel_d;
					if (!dual_q) begin
						cfg_addr <= `DPF_LIM_SINGLE;
					end else begin
						cfg_addr <= `DPF_LIM_DUAL | (sel_d ? `DPF_INACT_BASE : 24'h000000);
					end
					ld_q <= dpf_pkg::LD_LIM;
				end
				dpf_pkg::LD_LIM: begin
					lim_q <= cfg_rdata[12:0];
					alt_vec_dis_q <= cfg_rdata[15];
					cfg_addr <= `DPF_SEC_DUAL | (reset_sel_q ? 24'h000000 : `DPF_INACT_BASE);
					ld_q <= dpf_pkg::LD_SEC;
				end
				dpf_pkg::LD_SEC: begin
					// Taken once per reset; a run-time swap keeps the old protection
					inact_wp_q <= dual_q & cfg_rdata[0];
					cfg_done <= 1'b1;
					ld_q <= dpf_pkg::LD_RUN;
				end
				dpf_pkg::LD_RUN: begin
					ld_q <= dpf_pkg::LD_RUN;
				end
				default: begin
					ld_q <= dpf_pkg::LD_START;
				end
			endcase
		end
	end

	// ==========================================================
	// AHB-Lite slave
	logic wr_ph_q;
	logic [4:0] wofs_q;
	logic swap_req;
	logic clr_req;
	logic cmd_req;
	logic err_q;
	logic err_set;
	logic [31:0] rd_d;
	logic [23:0] paddr_q;
	wire logic take = hsel & htrans[1] & hready;
	assign swap_req = wr_ph_q && (wofs_q == `DPF_OFS_CTRL) && hwdata[0];
	assign clr_req = wr_ph_q && (wofs_q == `DPF_OFS_CTRL) && hwdata[1];
	assign cmd_req = wr_ph_q && (wofs_q == `DPF_OFS_PCMD) && (hwdata[1:0] != 2'b00);
	always_comb begin
		unique case (haddr[4:0])
			`DPF_OFS_STATUS: rd_d = {27'h0000000, err_q, reset_sel_q, dual_q, cfg_done, active_q};
			// Reads back the staged target, not the last issued one
			`DPF_OFS_PADDR: rd_d = {8'h00, paddr_q};
			`DPF_OFS_SEQ1: rd_d = {8'h00, seq1_q};
			`DPF_OFS_SEQ2: rd_d = {8'h00, seq2_q};
			`DPF_OFS_LIM: rd_d = {16'h0000, alt_vec_dis_q, 2'b00, lim_q};
			default: rd_d = 32'h00000000;
		endcase
	end
	// Zero wait states; read data is fetched in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_q <= 1'b0;
			wofs_q <= 5'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (ce) begin
			wr_ph_q <= take & hwrite & (haddr[31:5] == 27'h0000000);
			wofs_q <= haddr[4:0];
			hrdata <= (take && !hwrite && haddr[31:5] == 27'h0000000) ? rd_d : 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ==========================================================
	// Partition swap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active_q <= 1'b0;
		end else if (ce) begin
			if (ld_q == dpf_pkg::LD_SEQ2) begin
				active_q <= dual_q & sel_d;
			end else if (swap_req && dual_q && cfg_done) begin
				active_q <= !active_q;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			second_partition_active_flag <= 1'b0;
		end else if (ce) begin
			second_partition_active_flag <= active_q;
		end
	end

	// ==========================================================
	// Program and erase commands
	wire logic otp_tgt = in_rng(paddr_q & `DPF_PAGE_MASK, `DPF_OTP_LO & `DPF_PAGE_MASK, `DPF_OTP_HI);
	wire logic cmd_bad = cmd_req && (hwdata[1:0] == 2'b10) && otp_tgt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			paddr_q <= 24'h000000;
			prog_go <= 1'b0;
			prog_kind <= 2'b00;
			prog_addr <= 24'h000000;
		end else if (ce) begin
			if (wr_ph_q && wofs_q == `DPF_OFS_PADDR) begin
				paddr_q <= hwdata[23:0];
			end
			prog_go <= cmd_req & !cmd_bad;
			if (cmd_req && !cmd_bad) begin
				prog_kind <= hwdata[1:0];
				prog_addr <= (hwdata[1:0] == 2'b01) ? (paddr_q & `DPF_ROW_MASK) : (paddr_q & `DPF_PAGE_MASK);
			end
		end
	end

	// ==========================================================
	// Address map
	logic [23:0] la;
	logic tbl;
	logic [23:0] boot_seg_end;
	logic [23:0] alt_vec_lo;
	logic boot_seg_on;
	dpf_pkg::dpf_map_t m_d;
	always_comb begin
		tbl = (acc.kind == dpf_pkg::ACC_TBL_RD) || (acc.kind == dpf_pkg::ACC_TBL_WR);
		if (acc.kind == dpf_pkg::ACC_FETCH) begin
			la = {1'b0, acc.pc[22:1], 1'b0};
		end else if (acc.kind == dpf_pkg::ACC_REMAP) begin
			la = {1'b0, acc.table_page_reg[6:0], acc.offset};
		end else begin
			la = {acc.table_page_reg, acc.offset};
		end
		boot_seg_on = (lim_q > 13'h0001);
		boot_seg_end = {lim_q[12:0], 11'h000};
		alt_vec_lo = {(lim_q - 13'h0001), 11'h000};
		m_d.valid = acc.valid & cfg_done;
		m_d.err = 1'b0;
		m_d.upper_word = la[0];
		m_d.laddr = la;
		m_d.paddr = la;
		m_d.phys_part = 1'b0;
		m_d.region = dpf_pkg::RG_NONE;
		if (la[23]) begin
			if (!tbl) begin
				m_d.err = 1'b1;
			end else if (in_rng(la, `DPF_OTP_LO, `DPF_OTP_HI)) begin
				m_d.region = dpf_pkg::RG_OTP;
			end else if (in_rng(la, `DPF_CFG_LO, `DPF_CFG_HI)) begin
				m_d.region = dpf_pkg::RG_CFG;
			end else begin
				m_d.err = 1'b1;
			end
		end else if (dual_q && la[22]) begin
			m_d.region = dpf_pkg::RG_INACT;
			m_d.phys_part = !active_q;
			m_d.paddr = {1'b0, !active_q, la[21:0]};
			m_d.err = (acc.kind == dpf_pkg::ACC_TBL_WR) && inact_wp_q;
		end else begin
			m_d.phys_part = dual_q & active_q;
			m_d.paddr = dual_q ? {1'b0, active_q, la[21:0]} : la;
			if (la < `DPF_RST_END) begin
				m_d.region = dpf_pkg::RG_RESET;
			end else if (la < `DPF_PRIM_VEC_END) begin
				m_d.region = dpf_pkg::RG_PRIM_VEC;
			end else if (la < `DPF_VEC_END) begin
				m_d.region = dpf_pkg::RG_VEC_RSVD;
			end else if (boot_seg_on && !alt_vec_dis_q && la >= alt_vec_lo && la < boot_seg_end) begin
				m_d.region = dpf_pkg::RG_ALT_VEC;
			end else if (boot_seg_on && la < boot_seg_end) begin
				m_d.region = dpf_pkg::RG_BOOT;
			end else begin
				m_d.region = dpf_pkg::RG_GEN;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			map <= '0;
		end else if (ce) begin
			map <= m_d;
		end
	end
	// Sticky fault; a new fault wins over a clear in the same cycle
	assign err_set = cmd_bad | (m_d.valid & m_d.err);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_q <= 1'b0;
		end else if (ce) begin
			err_q <= err_set | (err_q & !clr_req);
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_fetch_even: assert property (ce && acc.valid && cfg_done && acc.kind == dpf_pkg::ACC_FETCH
		|=> map.valid && !map.laddr[0] && !map.laddr[23]) else $error("fetch address not even");
	chk_user_limit: assert property (ce && acc.valid && cfg_done && la[23]
		&& (!tbl || !in_rng(la, `DPF_OTP_LO, `DPF_CFG_HI)) |=> map.err) else $error("user access above 7FFFFFh not refused");
	chk_dual_map: assert property (map.valid && dual_q && !map.laddr[23]
		|-> map.phys_part == (map.laddr[22] ^ second_partition_active_flag)) else $error("partition map wrong");
	chk_single_map: assert property (map.valid && !dual_q && !map.laddr[23]
		|-> map.paddr == map.laddr && !map.phys_part) else $error("single mode not contiguous");
	chk_swap_flip: assert property (ce && swap_req && dual_q && cfg_done
		|=> active_q != $past(active_q) && $stable(reset_sel_q)) else $error("swap did not exchange");
	chk_flag_follow: assert property (ce |=> second_partition_active_flag == $past(active_q))
		else $error("active flag stale");
	chk_otp_keep: assert property (ce && cmd_bad |=> !prog_go && err_q)
		else $error("OTP erase issued");
	chk_blk_align: assert property (prog_go && prog_kind == 2'b01 |-> prog_addr[7:0] == 8'h00)
		else $error("row write not aligned");
	chk_page_align: assert property (prog_go && prog_kind != 2'b01 |-> prog_addr[10:0] == 11'h000)
		else $error("erase not page aligned");
	chk_seq_equal: assert property (ce && ld_q == dpf_pkg::LD_SEQ2 && dual_q && cfg_rdata == seq1_q
		|=> !active_q && ld_q == dpf_pkg::LD_LIM) else $error("equal sequence numbers not partition 1");
	chk_sel_hold: assert property (ce && cfg_done |=> $stable(reset_sel_q) && $stable(dual_q))
		else $error("reset selection moved after load");
	chk_map_gate: assert property (ce && !cfg_done |=> !map.valid)
		else $error("access mapped before config load");
	chk_inact_wp: assert property (ce && acc.valid && cfg_done && acc.kind == dpf_pkg::ACC_TBL_WR
		&& dual_q && la[22] && !la[23] && inact_wp_q |=> map.err) else $error("protected inactive write passed");
	chk_load_order: assert property (ld_q == dpf_pkg::LD_START && ce
		|=> ld_q == dpf_pkg::LD_FBOOT) else $error("config load did not start");
endmodule

// file: bench/dpf_flash_model.sv
// Purpose: flash configuration store read by the map during its load
// Assumes: word stands in the cycle after its address is registered
// Notes: unlisted addresses read as erased flash
`timescale 1ns/10ps
module dpf_flash_model (
	input wire logic [23:0] cfg_addr, // Word address
	output logic [23:0] cfg_rdata, // Word data
	input wire logic [23:0] fboot_w, // Boot mode word
	input wire logic [23:0] seq1_w, // Partition 1 sequence word
	input wire logic [23:0] seq2_w, // Partition 2 sequence word
	input wire logic [23:0] lim_w, // Segment limit word
	input wire logic [23:0] sec_w // Security word
);
	// ==========================================================
	// Config words, all 24 bits served
	// Address is already a flop in the map, so a second flop here would cost a cycle
	always_comb begin
		case (cfg_addr)
			24'h801800: cfg_rdata = fboot_w;
			24'h055FFC: cfg_rdata = seq1_w;
			24'h455FFC: cfg_rdata = seq2_w;
			24'h055F10, 24'h455F10, 24'h0ABF10: cfg_rdata = lim_w;
			24'h055F00, 24'h455F00, 24'h0ABF00: cfg_rdata = sec_w;
			default: cfg_rdata = 24'hFFFFFF;
		endcase
	end
endmodule

// file: bench/dpf_flash_map_tb_top.sv
// Purpose: self-checking bench of the flash map
// Assumes: zero wait state slave, map one cycle after request
// Notes: boot words change across a reset, except s1, which t_reprog changes at run time
`timescale 1ns/10ps
module dpf_flash_map_tb_top;
	localparam logic [23:0] DUAL = 24'hFFFFFC;
	localparam logic [23:0] SINGLE = 24'hFFFFFF;
	logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, cfg_done, flag, prog_go;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, prog_kind;
	logic [2:0] hsize;
	logic [23:0] cfg_addr, cfg_rdata, prog_addr, fb, s1, s2, lim, sec;
	dpf_pkg::dpf_acc_t acc;
	dpf_pkg::dpf_map_t map;
	int fails, samples_checked;
	assign hready = hreadyout;
	dpf_flash_map u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .acc(acc), .map(map), .cfg_done(cfg_done),
		.second_partition_active_flag(flag), .prog_go(prog_go), .prog_kind(prog_kind), .prog_addr(prog_addr));
	dpf_flash_model u_flash (.cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .fboot_w(fb), .seq1_w(s1),
		.seq2_w(s2), .lim_w(lim), .sec_w(sec));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// ==========================================================
	// Shared tasks
	function automatic logic [23:0] seqw(input logic [11:0] n);
		return {~n, n};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task end_sim();
		if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		chk(32'(hresp), 0);
	endtask
	task boot(input logic [23:0] f, input logic [23:0] a, input logic [23:0] b);
		@(posedge hclk);
		fb <= f;
		s1 <= a;
		s2 <= b;
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (12) begin
			@(posedge hclk);
			if (cfg_done === 1'b1) break;
		end
		chk(32'(cfg_done), 1);
	endtask
	task acck(input dpf_pkg::dpf_kind_t k, input logic [22:0] pc, input logic [7:0] pg, input logic [15:0] of,
		input logic [23:0] la, input dpf_pkg::dpf_region_t rg, input logic er);
		@(posedge hclk);
		acc <= {1'b1, k, pc, pg, of};
		@(posedge hclk);
		acc <= '0;
		#1;
		chk(32'(map.valid), 1);
		chk(32'(map.err), 32'(er));
		if (!er) begin
			chk(32'(map.laddr), 32'(la));
			chk(32'(map.region), 32'(rg));
			chk(32'(map.upper_word), 32'(la[0]));
		end
	endtask
	// ==========================================================
	// Scenarios
	task t_select();
		logic [23:0] f[5], a[5], b[5];
		logic e[5];
		f = '{DUAL, DUAL, DUAL, DUAL, SINGLE};
		a = '{seqw(5), seqw(3), 24'h0, 24'h0, seqw(5)};
		b = '{seqw(3), seqw(3), 24'h0, seqw(12'hFFF), seqw(3)};
		e = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 5; i++) begin
			boot(f[i], a[i], b[i]);
			bus(1'b0, 32'h04, 32'h0);
			chk(32'(flag), 32'(e[i]));
			chk(32'(rd[3:0]), 32'({e[i], ~f[i][0], 1'b1, e[i]}));
			if (i == 4) begin
				acck(dpf_pkg::ACC_FETCH, 23'h5000, 8'h0, 16'h0, 24'h005000, dpf_pkg::RG_GEN, 1'b0);
				chk(32'(map.paddr), 32'h00005000);
			end
		end
	endtask
	task t_reprog();
		boot(DUAL, seqw(2), seqw(1));
		s1 <= seqw(0);
		repeat (10) @(posedge hclk);
		chk(32'(flag), 1);
		boot(DUAL, seqw(0), seqw(1));
		chk(32'(flag), 0);
	endtask
	task t_swap();
		bus(1'b1, 32'h00, 32'h1);
		bus(1'b0, 32'h04, 32'h0);
		chk(32'(rd[3:0]), 32'h7);
		chk(32'(flag), 1);
		acck(dpf_pkg::ACC_FETCH, 23'h3000, 8'h0, 16'h0, 24'h003000, dpf_pkg::RG_GEN, 1'b0);
		chk(32'(map.phys_part), 1);
		chk(32'(map.paddr), 32'h00403000);
		acck(dpf_pkg::ACC_TBL_RD, 23'h0, 8'h40, 16'h0100, 24'h400100, dpf_pkg::RG_INACT, 1'b0);
		chk(32'(map.phys_part), 0);
		chk(32'(map.paddr), 32'h00000100);
		bus(1'b1, 32'h00, 32'h1);
		bus(1'b0, 32'h04, 32'h0);
		chk(32'(rd[3:0]), 32'h6);
	endtask
	task t_map();
		acck(dpf_pkg::ACC_FETCH, 23'h0, 8'h0, 16'h0, 24'h0, dpf_pkg::RG_RESET, 1'b0);
		acck(dpf_pkg::ACC_FETCH, 23'h0080, 8'h0, 16'h0, 24'h000080, dpf_pkg::RG_PRIM_VEC, 1'b0);
		acck(dpf_pkg::ACC_FETCH, 23'h0180, 8'h0, 16'h0, 24'h000180, dpf_pkg::RG_VEC_RSVD, 1'b0);
		acck(dpf_pkg::ACC_FETCH, 23'h1001, 8'h0, 16'h0, 24'h001000, dpf_pkg::RG_BOOT, 1'b0);
		acck(dpf_pkg::ACC_FETCH, 23'h1800, 8'h0, 16'h0, 24'h001800, dpf_pkg::RG_ALT_VEC, 1'b0);
		acck(dpf_pkg::ACC_REMAP, 23'h0, 8'h81, 16'h0083, 24'h010083, dpf_pkg::RG_GEN, 1'b0);
		acck(dpf_pkg::ACC_TBL_RD, 23'h0, 8'h80, 16'h1700, 24'h801700, dpf_pkg::RG_OTP, 1'b0);
		acck(dpf_pkg::ACC_TBL_RD, 23'h0, 8'h80, 16'h1800, 24'h801800, dpf_pkg::RG_CFG, 1'b0);
		acck(dpf_pkg::ACC_TBL_RD, 23'h0, 8'h80, 16'h4000, 24'h804000, dpf_pkg::RG_NONE, 1'b1);
		acck(dpf_pkg::ACC_TBL_WR, 23'h0, 8'h40, 16'h0, 24'h400000, dpf_pkg::RG_INACT, 1'b1);
		acck(dpf_pkg::ACC_TBL_WR, 23'h0, 8'h00, 16'h3000, 24'h003000, dpf_pkg::RG_GEN, 1'b0);
	endtask
	// Requests made while ce is low must not be mapped
	task t_freeze();
		@(posedge hclk);
		ce <= 1'b0;
		acc <= {1'b1, dpf_pkg::ACC_FETCH, 23'h0, 8'h00, 16'h0000};
		repeat (2) @(posedge hclk);
		#1;
		chk(32'(map.valid), 0);
		@(posedge hclk);
		ce <= 1'b1;
		@(posedge hclk);
		acc <= '0;
		#1;
		chk(32'(map.valid), 1);
	endtask
	// OTP is never programmed here, so no location is written twice
	task t_prog();
		logic [1:0] kd[4];
		logic [23:0] ad[4], ex[4];
		int n;
		kd = '{2'd1, 2'd2, 2'd3, 2'd2};
		ad = '{24'h001234, 24'h001234, 24'h001234, 24'h801234};
		ex = '{24'h001200, 24'h001000, 24'h001000, 24'h0};
		// Map faults from earlier scenarios would hide the OTP fault
		bus(1'b1, 32'h00, 32'h2);
		bus(1'b0, 32'h04, 32'h0);
		chk(32'(rd[4]), 0);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 32'h08, 32'(ad[i]));
			bus(1'b1, 32'h0C, 32'(kd[i]));
			n = 0;
			repeat (4) begin
				@(posedge hclk);
				if (prog_go === 1'b1) n++;
			end
			chk(32'(n), 32'(i < 3));
			if (i < 3) chk(32'({prog_kind, prog_addr}), 32'({kd[i], ex[i]}));
		end
		bus(1'b0, 32'h04, 32'h0);
		chk(32'(rd[4]), 1);
		bus(1'b1, 32'h00, 32'h2);
		bus(1'b0, 32'h04, 32'h0);
		chk(32'(rd[4]), 0);
	endtask
	task t_regs();
		bus(1'b0, 32'h18, 32'h0);
		chk(rd, 32'h00000004);
		bus(1'b0, 32'h10, 32'h0);
		chk(rd, 32'(s1));
		bus(1'b0, 32'h20, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 32'h08, 32'hFFFFFFFF);
		bus(1'b0, 32'h08, 32'h0);
		chk(rd, 32'h00FFFFFF);
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b1;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = '0;
		acc = '0;
		fb = DUAL;
		s1 = '0;
		s2 = '0;
		lim = 24'h000004;
		sec = 24'hFFFFFF;
		fails = 0;
		samples_checked = 0;
		t_select();
		t_reprog();
		t_swap();
		t_map();
		t_freeze();
		t_prog();
		t_regs();
		end_sim();
	end
	initial begin
		repeat (5000) @(posedge hclk);
		fails++;
		end_sim();
	end
endmodule
